// ### bench/sbms_check_monitor.sv
/*
 Checker for sbms_selector, bound to its ports.
 Assumes settings stay still across one stop sequence.
*/
`timescale 1ns/1ps
`default_nettype none
module sbms_check_monitor #(
   parameter longint TICK_CYCLES = 10
) (
   input wire logic        CLOCK_IN,              // Clock
   input wire logic        RESET_IN,              // Reset
   input wire logic [1:0]  CTRL_METHOD_IN,        // Method
   input wire logic [15:0] BRAKE_HOLD_TIME_IN,    // Hold time
   input wire logic [7:0]  BRAKE_INJECT_LEVEL_IN, // Level
   input wire logic        RUN_CMD_IN,            // Start cmd
   input wire logic        AUTOTUNE_REQ_IN,       // Tune req
   input wire logic [1:0]  HOLD_ACTION_OUT,       // Action
   input wire logic [7:0]  INJECT_LEVEL_OUT,      // DC level
   input wire logic        DRIVE_ENABLE_OUT,      // Output on
   input wire logic        AUTOTUNE_GO_OUT,       // Tune runs
   input wire logic        TUNE_SKIPPED_OUT,      // Skipped
   input wire logic        SETTING_ERR_OUT        // Range bad
);
   logic [25:0] set_q;
   logic [25:0] set2_q;
   logic [31:0] hold_len_q;
   wire logic [25:0] set_now = {CTRL_METHOD_IN, BRAKE_HOLD_TIME_IN,
                                BRAKE_INJECT_LEVEL_IN};
   // Settings unchanged over the last two edges
   wire logic still = (set_now == set_q) && (set_q == set2_q);
   wire logic vf_m = CTRL_METHOD_IN < 2'h2;
   wire logic [7:0] lvl_c = BRAKE_INJECT_LEVEL_IN > 8'h1E ? 8'h1E
                                                          : BRAKE_INJECT_LEVEL_IN;
   wire logic bad_set = (BRAKE_HOLD_TIME_IN > 16'h0064 &&
                         BRAKE_HOLD_TIME_IN != 16'h22B8) ||
                        BRAKE_INJECT_LEVEL_IN > 8'h1E;

   always_ff @(posedge CLOCK_IN or posedge RESET_IN) begin
      if (RESET_IN) begin
         set_q <= '0;
         set2_q <= '0;
      end else begin
         set_q <= set_now;
         set2_q <= set_q;
      end
   end

   always_ff @(posedge CLOCK_IN or posedge RESET_IN) begin
      if (RESET_IN)
         hold_len_q <= '0;
      else if (HOLD_ACTION_OUT == 2'h0)
         hold_len_q <= '0;
      else
         hold_len_q <= hold_len_q + 32'h1;
   end

   // ==========
   // Checks
   default clocking cb @(posedge CLOCK_IN); endclocking
   default disable iff (RESET_IN);

   inject_gate_a: assert property (HOLD_ACTION_OUT != 2'h1 |->
      INJECT_LEVEL_OUT == 8'h00) else $error("level without dc hold");
   level_range_a: assert property (INJECT_LEVEL_OUT <= 8'h1E)
      else $error("inject level above limit");
   dc_level_a: assert property (HOLD_ACTION_OUT == 2'h1 && still |->
      INJECT_LEVEL_OUT == lvl_c) else $error("dc level mismatch");
   vf_dc_only_a: assert property (vf_m && still |->
      HOLD_ACTION_OUT inside {2'h0, 2'h1}) else $error("vf hold not dc");
   zero_time_a: assert property (vf_m && still &&
      BRAKE_HOLD_TIME_IN == 16'h0000 |-> HOLD_ACTION_OUT == 2'h0)
      else $error("hold with zero time");
   zero_level_a: assert property (vf_m && still &&
      BRAKE_INJECT_LEVEL_IN == 8'h00 |-> HOLD_ACTION_OUT == 2'h0)
      else $error("dc hold with zero level");
   drive_on_hold_a: assert property (HOLD_ACTION_OUT != 2'h0 |->
      DRIVE_ENABLE_OUT) else $error("hold without drive");
   tune_excl_a: assert property (AUTOTUNE_GO_OUT || TUNE_SKIPPED_OUT |->
      $past(AUTOTUNE_REQ_IN) && !(AUTOTUNE_GO_OUT && TUNE_SKIPPED_OUT))
      else $error("tune outputs wrong");
   run_abort_a: assert property (RUN_CMD_IN ##1 RUN_CMD_IN |->
      ##1 HOLD_ACTION_OUT == 2'h0) else $error("hold during run");
   hold_len_a: assert property (vf_m && BRAKE_HOLD_TIME_IN != 16'h0 &&
      BRAKE_HOLD_TIME_IN <= 16'h0064 |->
      hold_len_q <= BRAKE_HOLD_TIME_IN * TICK_CYCLES + 4)
      else $error("timed hold too long");
   err_flag_a: assert property (still |->
      SETTING_ERR_OUT == bad_set) else $error("setting error flag wrong");

   dc_c: cover property (HOLD_ACTION_OUT == 2'h1);
   zero_c: cover property (HOLD_ACTION_OUT == 2'h2);
   servo_c: cover property (HOLD_ACTION_OUT == 2'h3);
   skip_c: cover property (TUNE_SKIPPED_OUT);
endmodule : sbms_check_monitor

bind sbms_selector sbms_check_monitor #(.TICK_CYCLES(TICK_CYCLES)) u_mon (
   .CLOCK_IN(CLOCK_IN), .RESET_IN(RESET_IN),
   .CTRL_METHOD_IN(CTRL_METHOD_IN), .BRAKE_HOLD_TIME_IN(BRAKE_HOLD_TIME_IN),
   .BRAKE_INJECT_LEVEL_IN(BRAKE_INJECT_LEVEL_IN), .RUN_CMD_IN(RUN_CMD_IN),
   .AUTOTUNE_REQ_IN(AUTOTUNE_REQ_IN), .HOLD_ACTION_OUT(HOLD_ACTION_OUT),
   .INJECT_LEVEL_OUT(INJECT_LEVEL_OUT), .DRIVE_ENABLE_OUT(DRIVE_ENABLE_OUT),
   .AUTOTUNE_GO_OUT(AUTOTUNE_GO_OUT), .TUNE_SKIPPED_OUT(TUNE_SKIPPED_OUT),
   .SETTING_ERR_OUT(SETTING_ERR_OUT));
`default_nettype wire

// ### bench/sbms_far_end.sv
/*
 Far-side model: contacts wired to the pre-excitation and brake
 timing terminals. Assumes the bench closes and opens them.
*/
`timescale 1ns/1ps
`default_nettype none
module sbms_far_end (
   input  wire logic preexcite_cmd_in,  // Contact closed
   input  wire logic brake_cmd_in,      // Contact closed
   output wire logic preexcite_pin_out, // Terminal level
   output wire logic brake_pin_out      // Terminal level
);
   // Contacts switch mid-cycle, unrelated to the drive clock
   assign #2 preexcite_pin_out = preexcite_cmd_in;
   assign #2 brake_pin_out = brake_cmd_in;
endmodule : sbms_far_end
`default_nettype wire

// ### bench/tb_top.sv
/*
 Self-checking bench for sbms_selector with the far-side model.
 Assumes a short tick so that timed holds stay brief.
*/
`timescale 1ns/1ps
`default_nettype none
module tb_top;
   logic clk = 0, rst = 1, sdef = 0, psel = 0, asel = 0, dec = 0, run = 0;
   logic atr = 0, lxc = 0, x13c = 0, den, tgo, tsk, err;
   wire logic lxp, x13p;
   logic [1:0] meth = 0, mode = 0, act;
   logic [15:0] bsf = 16'h012C, forward_start_cmd = 16'h0032, bht = 16'h0005;
   logic [15:0] ofq = 16'h0000;
   logic [7:0] lvl = 8'h07, ilv;
   int failures = 0, n_compared = 0;
   // Entries 0..7 are stop cases, 8..11 pre-excitation cases
   logic [1:0] tm[12] = '{0, 1, 2, 2, 3, 3, 3, 3, 2, 3, 0, 3};
   logic [1:0] tmd[12] = '{0, 0, 0, 1, 0, 0, 1, 2, 0, 0, 0, 2};
   logic tps[12] = '{0, 0, 0, 0, 0, 1, 1, 1, 0, 1, 0, 1};
   logic tas[12] = '{0, 0, 0, 1, 0, 0, 0, 0, 0, 0, 0, 0};
   logic [1:0] tex[12] = '{1, 1, 1, 2, 2, 3, 2, 0, 2, 3, 0, 3};

   always #2 clk = ~clk;

   sbms_selector #(.TICK_CYCLES(10)) u_sbms_selector (
      .CLOCK_IN(clk), .RESET_IN(rst), .CTRL_METHOD_IN(meth),
      .CTRL_MODE_IN(mode), .BRAKE_START_FREQ_IN(bsf),
      .START_FREQ_DEF_IN(sdef), .STARTING_FREQ_IN(forward_start_cmd),
      .BRAKE_HOLD_TIME_IN(bht), .BRAKE_INJECT_LEVEL_IN(lvl),
      .PREEXCITE_SELECT_IN(psel), .BRAKE_ACTION_SELECT_IN(asel),
      .OUTPUT_FREQ_IN(ofq), .DECEL_STOP_IN(dec), .RUN_CMD_IN(run),
      .AUTOTUNE_REQ_IN(atr), .PREEXCITE_IN(lxp), .EXT_BRAKE_TIMING_IN(x13p),
      .HOLD_ACTION_OUT(act), .INJECT_LEVEL_OUT(ilv),
      .DRIVE_ENABLE_OUT(den), .AUTOTUNE_GO_OUT(tgo),
      .TUNE_SKIPPED_OUT(tsk), .SETTING_ERR_OUT(err));

   sbms_far_end u_sbms_far_end (
      .preexcite_cmd_in(lxc), .brake_cmd_in(x13c),
      .preexcite_pin_out(lxp), .brake_pin_out(x13p));

   // ==========
   // Tasks
   task chk(input logic [15:0] seen, input logic [15:0] exp);
      n_compared++;
      if (seen !== exp) begin
         failures++;
         $display("wrong value at %0t: seen %0h expected %0h", $time,
                  seen, exp);
      end
   endtask : chk

   task step(input int n);
      repeat (n) @(posedge clk);
      #1;
   endtask : step

   task cfg(input logic [1:0] m, md, input logic ps, as);
      meth = m;
      mode = md;
      psel = ps;
      asel = as;
      step(2);
   endtask : cfg

   task stop(input logic [15:0] f, input logic [1:0] a,
             input logic [7:0] l);
      ofq = f;
      dec = 1;
      step(3);
      chk(act, a);
      chk(ilv, l);
   endtask : stop

   // A start command is a clean way out of every hold state
   task idle;
      dec = 0;
      lxc = 0;
      x13c = 0;
      atr = 0;
      run = 1;
      step(2);
      run = 0;
      step(2);
   endtask : idle

   task done_t(input string s);
      $display("test %0s done", s);
   endtask : done_t

   task finish_test;
      $display("compared %0d, failures %0d", n_compared, failures);
      if (failures == 0 && n_compared > 0)
         $display("RESULT: PASS");
      else
         $display("RESULT: FAIL");
      $finish;
   endtask : finish_test

   // ==========
   // Tests
   initial begin
      step(3);
      rst = 0;
      step(4);
      for (int i = 0; i < 8; i++) begin
         cfg(tm[i], tmd[i], tps[i], tas[i]);
         stop(16'h012C, tex[i], tex[i] == 2'h1 ? 8'h07 : 8'h00);
         idle;
      end
      done_t("modes");
      cfg(0, 0, 0, 0);
      stop(16'h012D, 0, 0);
      stop(16'h012C, 1, 8'h07);
      idle;
      bsf = 16'h270F;
      forward_start_cmd = 16'h0064;
      stop(16'h0065, 0, 0);
      stop(16'h0064, 1, 8'h07);
      idle;
      bsf = 16'h012C;
      sdef = 1;
      cfg(3, 0, 0, 0);
      stop(16'h0033, 0, 0);
      stop(16'h0032, 2, 0);
      idle;
      cfg(0, 0, 0, 0);
      stop(16'h012D, 0, 0);
      stop(16'h012C, 1, 8'h07);
      idle;
      sdef = 0;
      done_t("threshold");
      cfg(0, 0, 0, 0);
      bht = 16'h0003;
      stop(0, 1, 8'h07);
      chk(den, 1);
      step(24);
      chk(act, 1);
      step(8);
      chk(act, 0);
      chk(den, 0);
      idle;
      // Pre-excitation held through a timed hold takes over at expiry
      cfg(2, 0, 0, 0);
      lxc = 1;
      stop(0, 1, 8'h07);
      step(34);
      chk(act, 2);
      chk(den, 1);
      idle;
      bht = 16'h0000;
      stop(0, 0, 0);
      idle;
      bht = 16'h0005;
      lvl = 8'h00;
      stop(0, 0, 0);
      idle;
      lvl = 8'h07;
      done_t("timing");
      bht = 16'h22B8;
      for (int i = 0; i < 2; i++) begin
         cfg(i ? 2'h2 : 2'h0, 0, 0, 0);
         stop(0, 0, 0);
         x13c = 1;
         step(8);
         chk(act, i ? 2'h2 : 2'h1);
         x13c = 0;
         step(8);
         chk(act, 0);
         idle;
      end
      bht = 16'h0005;
      done_t("external");
      bsf = 16'h0032;
      for (int i = 8; i < 12; i++) begin
         cfg(tm[i], tmd[i], tps[i], tas[i]);
         lxc = 1;
         step(8);
         chk(act, tex[i]);
         chk(den, tex[i] != 2'h0);
         atr = 1;
         step(3);
         chk(tsk, tex[i] != 2'h0);
         chk(tgo, tex[i] == 2'h0);
         atr = 0;
         lxc = 0;
         step(8);
         chk(act, 0);
         idle;
      end
      done_t("preexcite");
      cfg(0, 0, 0, 0);
      bht = 16'h0065;
      step(3);
      chk(err, 1);
      bht = 16'h0064;
      step(3);
      chk(err, 0);
      lvl = 8'h1F;
      step(3);
      chk(err, 1);
      stop(0, 1, 8'h1E);
      idle;
      lvl = 8'h07;
      bht = 16'h0005;
      done_t("ranges");
      finish_test;
   end

   // Whole run is about 400 cycles
   initial begin
      #100000;
      failures++;
      finish_test;
   end
endmodule : tb_top
`default_nettype wire

// ### pkg/sbms_pkg.sv
/*
 Shared constants for the stop brake mode selector: control methods,
 modes, hold actions, setting encodings and timing figures.
 Assumes frequencies arrive in 0.01 Hz units and times in 0.1 s units.
*/
`default_nettype none
package sbms_pkg;
   // Frequency in 0.01 Hz steps, time in 0.1 s steps
   localparam int FREQ_W = 16;
   localparam int TIME_W = 16;
   localparam int VOLT_W = 8;

   localparam logic [FREQ_W-1:0] FREQ_USE_STARTING = 16'h270F; // 9999
   localparam logic [FREQ_W-1:0] FREQ_DEFAULT      = 16'h012C; // 3 Hz
   localparam logic [FREQ_W-1:0] FREQ_VECTOR_DEF   = 16'h0032; // 0.5 Hz
   localparam logic [TIME_W-1:0] TIME_EXTERNAL     = 16'h22B8; // 8888
   localparam logic [TIME_W-1:0] TIME_ZERO         = 16'h0000;
   localparam logic [TIME_W-1:0] TIME_MIN          = 16'h0001; // 0.1 s
   localparam logic [TIME_W-1:0] TIME_MAX          = 16'h0064; // 10 s
   localparam logic [TIME_W-1:0] TIME_DEFAULT      = 16'h0005; // 0.5 s
   localparam logic [VOLT_W-1:0] VOLT_ZERO         = 8'h00;
   localparam logic [VOLT_W-1:0] VOLT_MAX          = 8'h1E;    // 30 %
   localparam logic [VOLT_W-1:0] VOLT_DEFAULT      = 8'h01;    // 1 %

   // One time unit is 100 ms
   localparam longint TICK_MS       = 100;
   localparam longint CLK_MHZ       = 250;
   localparam longint TICK_CYCLES   = TICK_MS * 1000 * CLK_MHZ;

   localparam int SYNC_STAGES = 3;

   typedef enum logic [1:0] {
      CM_VF, CM_FLUX, CM_SENSORLESS, CM_VECTOR
   } sbms_method_t;

   typedef enum logic [1:0] {
      MD_SPEED, MD_TORQUE, MD_POSITION
   } sbms_mode_t;

   typedef enum logic [1:0] {
      HOLD_NONE, HOLD_DC, HOLD_ZERO, HOLD_SERVO
   } sbms_hold_t;
endpackage : sbms_pkg
`default_nettype wire

// ### rtl/sbms_selector.sv
/*
 Stop brake mode selector: decides DC injection, zero speed or servo
 lock at a deceleration stop, on the pre-excitation input and on the
 external brake timing input, and times the brake interval.
 Assumes settings are static words from the parameter store and that
 output frequency is supplied by the speed ramp on the same clock.
*/
// Functional notes
// - Start holding when decelerating output reaches brake start frequency.
// - Start-frequency special value uses the starting frequency threshold.
// - Vector control makes default brake start frequency 0.5 Hz.
// - Holding lasts for the brake hold time setting.
// - Hold time accepts 0.1 to 10 s, default 0.5 s, or external.
// - Hold time zero means no holding; motor coasts.
// - External time value holds while brake timing input is asserted.
// - Sensorless with external timing input gives zero speed always.
// - Injection level is percent of supply, unused for zero speed/servo.
// - Injection level zero disables DC braking; motor coasts.
// - Sensorless: action select 1 zero speed, 0 DC injection.
// - Vector: preexcite select 0 zero speed, 1 servo lock.
// - V/F and flux: always DC injection, pre-excitation ignored.
// - Sensorless: pre-excitation gives zero speed; stop follows select.
// - Vector: speed per select, torque zero speed, position servo on input.
// - Pre-excitation holds zero speed or servo lock while stopped.
// - Sensorless torque pre-excitation may turn the motor slowly.
// - Auto tune request during pre-excitation is skipped; motor starts.
// - Injection level ranges 0 to 30 percent, default 1 percent.
`timescale 1ns/1ps
`default_nettype none
module sbms_selector #(
   parameter longint TICK_CYCLES = sbms_pkg::TICK_CYCLES
) (
   input  wire logic                        CLOCK_IN,          // Clock
   input  wire logic                        RESET_IN,          // Reset
   input  wire logic [1:0]                  CTRL_METHOD_IN,    // Method
   input  wire logic [1:0]                  CTRL_MODE_IN,      // Mode
   input  wire logic [sbms_pkg::FREQ_W-1:0] BRAKE_START_FREQ_IN, // 0.01Hz
   input  wire logic                        START_FREQ_DEF_IN, // Use def
   input  wire logic [sbms_pkg::FREQ_W-1:0] STARTING_FREQ_IN,  // 0.01Hz
   input  wire logic [sbms_pkg::TIME_W-1:0] BRAKE_HOLD_TIME_IN, // 0.1s
   input  wire logic [sbms_pkg::VOLT_W-1:0] BRAKE_INJECT_LEVEL_IN, // %
   input  wire logic                        PREEXCITE_SELECT_IN, // 0/1
   input  wire logic                        BRAKE_ACTION_SELECT_IN, // 0/1
   input  wire logic [sbms_pkg::FREQ_W-1:0] OUTPUT_FREQ_IN,    // 0.01Hz
   input  wire logic                        DECEL_STOP_IN,     // Stopping
   input  wire logic                        RUN_CMD_IN,        // Start cmd
   input  wire logic                        AUTOTUNE_REQ_IN,   // Tune req
   input  wire logic                        PREEXCITE_IN,      // Pin
   input  wire logic                        EXT_BRAKE_TIMING_IN, // Pin
   output logic [1:0]                       HOLD_ACTION_OUT,   // Action
   output logic [sbms_pkg::VOLT_W-1:0]      INJECT_LEVEL_OUT,  // DC %
   output logic                             DRIVE_ENABLE_OUT,  // Output on
   output logic                             AUTOTUNE_GO_OUT,   // Tune runs
   output logic                             TUNE_SKIPPED_OUT,  // Skipped
   output logic                             SETTING_ERR_OUT    // Range bad
);
   // ==========================================================
   // Pin inputs
   // ==========================================================
   logic preexcite_s;
   logic ext_timing_s;

   sbms_sync u_sync_pre (
      .clk_in    (CLOCK_IN),
      .rst_in    (RESET_IN),
      .async_in  (PREEXCITE_IN),
      .level_out (preexcite_s)
   );

   sbms_sync u_sync_ext (
      .clk_in    (CLOCK_IN),
      .rst_in    (RESET_IN),
      .async_in  (EXT_BRAKE_TIMING_IN),
      .level_out (ext_timing_s)
   );

   // ==========================================================
   // Setting decode
   // ==========================================================
   sbms_pkg::sbms_method_t      method;
   sbms_pkg::sbms_mode_t        mode;
   logic [sbms_pkg::FREQ_W-1:0] start_freq;
   logic [sbms_pkg::FREQ_W-1:0] threshold;
   logic                        time_ext;
   logic                        time_zero;
   logic [sbms_pkg::TIME_W-1:0] hold_units;
   logic [sbms_pkg::VOLT_W-1:0] inject_lvl;
   logic                        time_bad;
   logic                        volt_bad;

   assign method = sbms_pkg::sbms_method_t'(CTRL_METHOD_IN);
   assign mode   = sbms_pkg::sbms_mode_t'(CTRL_MODE_IN);

   // Default follows control method when no value was written
   always_comb begin
      if (!START_FREQ_DEF_IN) begin
         start_freq = BRAKE_START_FREQ_IN;
      end else if (method == sbms_pkg::CM_VECTOR) begin
         start_freq = sbms_pkg::FREQ_VECTOR_DEF;
      end else begin
         start_freq = sbms_pkg::FREQ_DEFAULT;
      end
   end

   always_comb begin
      if (start_freq == sbms_pkg::FREQ_USE_STARTING) begin
         threshold = STARTING_FREQ_IN;
      end else begin
         threshold = start_freq;
      end
   end

   assign time_ext  = (BRAKE_HOLD_TIME_IN == sbms_pkg::TIME_EXTERNAL);
   assign time_zero = (BRAKE_HOLD_TIME_IN == sbms_pkg::TIME_ZERO);
   // Out-of-range time falls back to the default, flagged to software
   assign time_bad  = !time_ext && !time_zero &&
                      (BRAKE_HOLD_TIME_IN > sbms_pkg::TIME_MAX);
   assign hold_units = time_bad ? sbms_pkg::TIME_DEFAULT
                                : BRAKE_HOLD_TIME_IN;
   // Level above range clamps rather than overdriving the winding
   assign volt_bad   = (BRAKE_INJECT_LEVEL_IN > sbms_pkg::VOLT_MAX);
   assign inject_lvl = volt_bad ? sbms_pkg::VOLT_MAX
                                : BRAKE_INJECT_LEVEL_IN;

   // ==========================================================
   // Action tables
   // ==========================================================
   sbms_pkg::sbms_hold_t stop_action;
   sbms_pkg::sbms_hold_t pre_action;
   sbms_pkg::sbms_hold_t ext_action;

   always_comb begin
      case (method)
         sbms_pkg::CM_SENSORLESS: begin
            stop_action = BRAKE_ACTION_SELECT_IN ? sbms_pkg::HOLD_ZERO
                                                 : sbms_pkg::HOLD_DC;
            pre_action  = sbms_pkg::HOLD_ZERO;
            ext_action  = sbms_pkg::HOLD_ZERO;
         end
         sbms_pkg::CM_VECTOR: begin
            case (mode)
               sbms_pkg::MD_SPEED: begin
                  stop_action = PREEXCITE_SELECT_IN ? sbms_pkg::HOLD_SERVO
                                                    : sbms_pkg::HOLD_ZERO;
                  pre_action  = stop_action;
                  ext_action  = stop_action;
               end
               sbms_pkg::MD_TORQUE: begin
                  stop_action = sbms_pkg::HOLD_ZERO;
                  pre_action  = sbms_pkg::HOLD_ZERO;
                  ext_action  = sbms_pkg::HOLD_ZERO;
               end
               sbms_pkg::MD_POSITION: begin
                  stop_action = sbms_pkg::HOLD_NONE;
                  pre_action  = sbms_pkg::HOLD_SERVO;
                  ext_action  = sbms_pkg::HOLD_NONE;
               end
               default: begin
                  stop_action = sbms_pkg::HOLD_NONE;
                  pre_action  = sbms_pkg::HOLD_NONE;
                  ext_action  = sbms_pkg::HOLD_NONE;
               end
            endcase
         end
         default: begin
            stop_action = sbms_pkg::HOLD_DC;
            pre_action  = sbms_pkg::HOLD_NONE;
            ext_action  = sbms_pkg::HOLD_DC;
         end
      endcase
   end

   // DC injection at zero level means coasting instead
   function automatic sbms_pkg::sbms_hold_t gate_dc(
      input sbms_pkg::sbms_hold_t act,
      input logic [sbms_pkg::VOLT_W-1:0] lvl
   );
      if (act == sbms_pkg::HOLD_DC && lvl == sbms_pkg::VOLT_ZERO) begin
         gate_dc = sbms_pkg::HOLD_NONE;
      end else begin
         gate_dc = act;
      end
   endfunction : gate_dc

   logic pre_on;
   assign pre_on = preexcite_s && (pre_action != sbms_pkg::HOLD_NONE);

   // ==========================================================
   // Stop sequence
   // ==========================================================
   typedef enum logic [1:0] {
      ST_IDLE, ST_TIMED, ST_EXTERNAL, ST_DONE
   } sbms_state_t;

   sbms_state_t state_q;
   sbms_state_t state_d;
   logic        reached;
   logic        timer_start;
   logic        timer_busy;
   logic        timer_done;

   assign reached = DECEL_STOP_IN && (OUTPUT_FREQ_IN <= threshold);

   always_comb begin
      state_d     = state_q;
      timer_start = 1'b0;
      case (state_q)
         ST_IDLE: begin
            if (reached && !RUN_CMD_IN) begin
               if (time_ext) begin
                  state_d = ST_EXTERNAL;
               end else if (time_zero ||
                            gate_dc(stop_action, inject_lvl) ==
                            sbms_pkg::HOLD_NONE) begin
                  state_d = ST_DONE;
               end else begin
                  state_d     = ST_TIMED;
                  timer_start = 1'b1;
               end
            end
         end
         ST_TIMED: begin
            if (RUN_CMD_IN) begin
               state_d = ST_IDLE;
            end else if (timer_done) begin
               state_d = ST_DONE;
            end
         end
         ST_EXTERNAL: begin
            if (RUN_CMD_IN || !time_ext) begin
               state_d = ST_IDLE;
            end
         end
         ST_DONE: begin
            if (RUN_CMD_IN || !DECEL_STOP_IN) begin
               state_d = ST_IDLE;
            end
         end
         default: begin
            state_d = ST_IDLE;
         end
      endcase
   end

   always_ff @(posedge CLOCK_IN or posedge RESET_IN) begin
      if (RESET_IN) begin
         state_q <= ST_IDLE;
      end else begin
         state_q <= state_d;
      end
   end

   sbms_timer #(
      .TICK_CYCLES (TICK_CYCLES)
   ) u_timer (
      .clk_in   (CLOCK_IN),
      .rst_in   (RESET_IN),
      .start_in (timer_start),
      .abort_in (RUN_CMD_IN),
      .units_in (hold_units),
      .busy_out (timer_busy),
      .done_out (timer_done)
   );

   // ==========================================================
   // Action output
   // ==========================================================
   sbms_pkg::sbms_hold_t act_d;
   logic                 ext_on;

   // External input holds in the external timing state or in the done state
   assign ext_on = time_ext && ext_timing_s && !RUN_CMD_IN &&
                   (state_q == ST_EXTERNAL || state_q == ST_DONE);

   always_comb begin
      act_d = sbms_pkg::HOLD_NONE;
      if (ext_on) begin
         act_d = gate_dc(ext_action, inject_lvl);
      end else if (state_q == ST_TIMED && timer_busy) begin
         act_d = gate_dc(stop_action, inject_lvl);
      end else if (pre_on && !RUN_CMD_IN) begin
         act_d = pre_action;
      end
   end

   always_ff @(posedge CLOCK_IN or posedge RESET_IN) begin
      if (RESET_IN) begin
         HOLD_ACTION_OUT  <= 2'h0;
         INJECT_LEVEL_OUT <= sbms_pkg::VOLT_ZERO;
         DRIVE_ENABLE_OUT <= 1'b0;
      end else begin
         HOLD_ACTION_OUT  <= act_d;
         // Level matters only while injecting
         INJECT_LEVEL_OUT <= (act_d == sbms_pkg::HOLD_DC) ? inject_lvl
                                                          : sbms_pkg::VOLT_ZERO;
         // Pre-excitation may turn the motor slowly in sensorless torque
         DRIVE_ENABLE_OUT <= RUN_CMD_IN || (act_d != sbms_pkg::HOLD_NONE);
      end
   end

   // ==========================================================
   // Auto tuning gate and setting check
   // ==========================================================
   always_ff @(posedge CLOCK_IN or posedge RESET_IN) begin
      if (RESET_IN) begin
         AUTOTUNE_GO_OUT  <= 1'b0;
         TUNE_SKIPPED_OUT <= 1'b0;
      end else begin
         AUTOTUNE_GO_OUT  <= AUTOTUNE_REQ_IN && !pre_on;
         TUNE_SKIPPED_OUT <= AUTOTUNE_REQ_IN && pre_on;
      end
   end

   always_ff @(posedge CLOCK_IN or posedge RESET_IN) begin
      if (RESET_IN) begin
         SETTING_ERR_OUT <= 1'b0;
      end else begin
         SETTING_ERR_OUT <= time_bad || volt_bad;
      end
   end
endmodule : sbms_selector
`default_nettype wire

// ### rtl/sbms_sync.sv
/*
 Three-stage input synchroniser with agreement check.
 Assumes the input is asynchronous to CLOCK_IN.
*/
`timescale 1ns/1ps
`default_nettype none
module sbms_sync (
   input  wire logic clk_in,   // Clock
   input  wire logic rst_in,   // Async reset, high
   input  wire logic async_in, // Raw pin
   output logic      level_out // Filtered level
);
   logic [sbms_pkg::SYNC_STAGES-1:0] stage_q;

   always_ff @(posedge clk_in or posedge rst_in) begin
      if (rst_in) begin
         stage_q <= '0;
      end else begin
         stage_q <= {stage_q[sbms_pkg::SYNC_STAGES-2:0], async_in};
      end
   end

   // Change counts once second and third stages agree
   always_ff @(posedge clk_in or posedge rst_in) begin
      if (rst_in) begin
         level_out <= 1'b0;
      end else if (stage_q[1] == stage_q[2]) begin
         level_out <= stage_q[2];
      end
   end
endmodule : sbms_sync
`default_nettype wire

// ### rtl/sbms_timer.sv
/*
 Brake interval timer counting 0.1 s ticks.
 Assumes start is a one-cycle pulse; abort stops the count at once.
*/
`timescale 1ns/1ps
`default_nettype none
module sbms_timer #(
   parameter longint TICK_CYCLES = sbms_pkg::TICK_CYCLES
) (
   input  wire logic                        clk_in,   // Clock
   input  wire logic                        rst_in,   // Async reset
   input  wire logic                        start_in, // Start pulse
   input  wire logic                        abort_in, // Stop counting
   input  wire logic [sbms_pkg::TIME_W-1:0] units_in, // Length, 0.1 s
   output logic                             busy_out, // Counting
   output logic                             done_out  // Expiry pulse
);
   logic [31:0]                 tick_q;
   logic [sbms_pkg::TIME_W-1:0] left_q;

   always_ff @(posedge clk_in or posedge rst_in) begin
      if (rst_in) begin
         tick_q   <= '0;
         left_q   <= '0;
         busy_out <= 1'b0;
         done_out <= 1'b0;
      end else begin
         done_out <= 1'b0;
         if (abort_in) begin
            busy_out <= 1'b0;
         end else if (start_in) begin
            tick_q   <= '0;
            left_q   <= units_in;
            busy_out <= 1'b1;
         end else if (busy_out) begin
            if (tick_q == 32'(TICK_CYCLES - 1)) begin
               tick_q <= '0;
               if (left_q == sbms_pkg::TIME_MIN) begin
                  busy_out <= 1'b0;
                  done_out <= 1'b1;
               end
               left_q <= left_q - sbms_pkg::TIME_MIN;
            end else begin
               tick_q <= tick_q + 32'h0000_0001;
            end
         end
      end
   end
endmodule : sbms_timer
`default_nettype wire
